//--- vdisp_dev.sv
// device end: serial slave host port with strap select and register handshake
// Behaviour
// - port enabled only for straps 0,0,1
// - straps latched just after reset release
// - slave only, never makes start/stop
// - address LSB follows the select pin
// - lines only pulled low, else released
// - handles any clock up to 400 kbit/s
// - data changes only while clock low
// - start with clock high restarts reception
// - stop with clock high returns to idle
// - ack is data low on ninth clock
// - bytes are eight bits plus ack
// - hold clock low until byte handled
// - receiver holds data low through ack
// - unmatched address left unacknowledged
// - slave refusing data leaves data high
// - release data after master's last nack
// - write: address, subaddress, data bytes, stop
// - subaddress never auto-increments
// - write address phase stores subaddress
// - read phase shifts out data bytes
`timescale 1ns/1ns
`default_nettype none
module vdisp_dev (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic LINK_CLK,
  input wire logic STRAP_BIT2_PIN,
  input wire logic STRAP_BIT1_PIN,
  input wire logic STRAP_BIT0_PIN,
  input wire logic ADDR_SELECT_PIN,
  vdisp_if.dev BUS,
  output logic PORT_EN,
  output logic WR_STB,
  output logic RD_STB,
  output logic [7:0] SUBADDR,
  output logic [7:0] WR_DATA,
  input wire logic [7:0] RD_DATA
);
  // link-side state, clocked by LINK_CLK
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    logic en_s1;
    logic en_s2;
    logic as_s1;
    logic as_s2;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    vdisp_pkg::vdisp_dst_t st;
    vdisp_pkg::vdisp_drole_t role;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] sub;
    logic [7:0] wdat;
    logic rd_kind;
    logic req_tg;
    logic pending;
    logic sda_low;
    logic scl_low;
  } vdisp_lnk_t;

  // register-side state, clocked by MCLK
  typedef struct packed {
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic [1:0] cap_cnt;
    logic cap_done;
    logic en;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic ack_tg;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] sub;
    logic [7:0] wdat;
    logic [7:0] rdat;
  } vdisp_reg_t;

  vdisp_lnk_t l_r;
  vdisp_lnk_t l_nxt;
  vdisp_reg_t m_r;
  vdisp_reg_t m_nxt;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic ack_ev;

  always_comb begin
    l_nxt = l_r;
    // [0] is the first flop, [1] the second, [2] the filter compare stage
    l_nxt.scl_s = {l_r.scl_s[1], l_r.scl_s[0], BUS.scl};
    l_nxt.sda_s = {l_r.sda_s[1], l_r.sda_s[0], BUS.sda};
    // a level is believed only after two agreeing samples
    if (l_r.scl_s[1] == l_r.scl_s[2]) begin
      l_nxt.scl_f = l_r.scl_s[1];
    end
    if (l_r.sda_s[1] == l_r.sda_s[2]) begin
      l_nxt.sda_f = l_r.sda_s[1];
    end
    l_nxt.en_s1 = m_r.en;
    l_nxt.en_s2 = l_r.en_s1;
    l_nxt.as_s1 = ADDR_SELECT_PIN;
    l_nxt.as_s2 = l_r.as_s1;
    l_nxt.ack_s1 = m_r.ack_tg;
    l_nxt.ack_s2 = l_r.ack_s1;
    l_nxt.ack_s3 = l_r.ack_s2;
    scl_rise = !l_r.scl_f && l_nxt.scl_f;
    scl_fall = l_r.scl_f && !l_nxt.scl_f;
    start_c = l_r.scl_f && l_nxt.scl_f && l_r.sda_f && !l_nxt.sda_f;
    stop_c = l_r.scl_f && l_nxt.scl_f && !l_r.sda_f && l_nxt.sda_f;
    ack_ev = l_r.ack_s2 != l_r.ack_s3;
    if (ack_ev) begin
      l_nxt.pending = 1'b0;
    end
    if (!l_r.en_s2) begin
      l_nxt.st = vdisp_pkg::DS_IDLE;
      l_nxt.sda_low = 1'b0;
      l_nxt.scl_low = 1'b0;
    end else if (start_c) begin
      // a start anywhere, repeated or not, begins a new address byte
      l_nxt.st = vdisp_pkg::DS_RX;
      l_nxt.role = vdisp_pkg::DR_ADDR;
      l_nxt.cnt = 4'h0;
      l_nxt.sda_low = 1'b0;
      l_nxt.scl_low = 1'b0;
    end else if (stop_c) begin
      l_nxt.st = vdisp_pkg::DS_IDLE;
      l_nxt.sda_low = 1'b0;
      l_nxt.scl_low = 1'b0;
    end else begin
      unique case (l_r.st)
        vdisp_pkg::DS_IDLE: begin
        end
        vdisp_pkg::DS_RX: begin
          if (scl_rise) begin
            // sampled on the rising edge, where the sender holds it stable
            l_nxt.sh = {l_r.sh[6:0], l_nxt.sda_f};
            l_nxt.cnt = l_r.cnt + 4'h1;
          end else if (scl_fall && l_r.cnt == vdisp_pkg::ACK_BIT) begin
            l_nxt.st = vdisp_pkg::DS_ACK;
            l_nxt.sda_low = 1'b1;
            unique case (l_r.role)
              vdisp_pkg::DR_ADDR: begin
                if (l_r.sh[7:1] == {vdisp_pkg::ADDR_UPPER, l_r.as_s2}) begin
                  if (l_r.sh[0]) begin
                    l_nxt.role = vdisp_pkg::DR_TX;
                    l_nxt.rd_kind = 1'b1;
                    l_nxt.req_tg = !l_r.req_tg;
                    l_nxt.pending = 1'b1;
                  end else begin
                    l_nxt.role = vdisp_pkg::DR_SUB;
                  end
                end else begin
                  // not ours: stay off the bus until the next start
                  l_nxt.st = vdisp_pkg::DS_IDLE;
                  l_nxt.sda_low = 1'b0;
                end
              end
              vdisp_pkg::DR_SUB: begin
                l_nxt.sub = l_r.sh;
                l_nxt.role = vdisp_pkg::DR_DATA;
              end
              default: begin
                // every data byte goes to the same subaddress
                l_nxt.wdat = l_r.sh;
                l_nxt.rd_kind = 1'b0;
                l_nxt.req_tg = !l_r.req_tg;
                l_nxt.pending = 1'b1;
                l_nxt.scl_low = 1'b1;
              end
            endcase
          end
        end
        vdisp_pkg::DS_ACK: begin
          if (ack_ev) begin
            l_nxt.scl_low = 1'b0;
          end
          if (scl_fall) begin
            l_nxt.sda_low = 1'b0;
            l_nxt.cnt = 4'h0;
            if (l_r.role == vdisp_pkg::DR_TX) begin
              if (l_r.pending && !ack_ev) begin
                // read data not back yet: stretch before driving bit 7
                l_nxt.scl_low = 1'b1;
                l_nxt.st = vdisp_pkg::DS_TXW;
              end else begin
                l_nxt.sh = m_r.rdat;
                l_nxt.sda_low = !m_r.rdat[7];
                l_nxt.st = vdisp_pkg::DS_TX;
              end
            end else begin
              l_nxt.st = vdisp_pkg::DS_RX;
            end
          end
        end
        vdisp_pkg::DS_TXW: begin
          if (ack_ev) begin
            // rdat is stable here: it only changes in the same cycle as the ack toggle
            l_nxt.sh = m_r.rdat;
            l_nxt.sda_low = !m_r.rdat[7];
            l_nxt.scl_low = 1'b0;
            l_nxt.st = vdisp_pkg::DS_TX;
          end
        end
        vdisp_pkg::DS_TX: begin
          if (scl_fall) begin
            if (l_r.cnt == vdisp_pkg::LAST_DATA_BIT) begin
              l_nxt.sda_low = 1'b0;
              l_nxt.st = vdisp_pkg::DS_TXA;
            end else begin
              l_nxt.sh = {l_r.sh[6:0], 1'b0};
              l_nxt.sda_low = !l_r.sh[6];
              l_nxt.cnt = l_r.cnt + 4'h1;
            end
          end
        end
        vdisp_pkg::DS_TXA: begin
          if (scl_rise) begin
            if (l_nxt.sda_f) begin
              // master's nack ends the read; data already released
              l_nxt.st = vdisp_pkg::DS_IDLE;
            end else begin
              l_nxt.st = vdisp_pkg::DS_ACK;
              l_nxt.rd_kind = 1'b1;
              l_nxt.req_tg = !l_r.req_tg;
              l_nxt.pending = 1'b1;
            end
          end
        end
        default: begin
          l_nxt.st = vdisp_pkg::DS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK or negedge RESETN) begin
    if (!RESETN) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  always_comb begin
    m_nxt = m_r;
    m_nxt.wr_stb = 1'b0;
    m_nxt.rd_stb = 1'b0;
    m_nxt.strap_s1 = {STRAP_BIT2_PIN, STRAP_BIT1_PIN, STRAP_BIT0_PIN};
    m_nxt.strap_s2 = m_r.strap_s1;
    if (!m_r.cap_done) begin
      if (m_r.cap_cnt == vdisp_pkg::STRAP_CAP_AT) begin
        // straps are caught once, right after reset release
        m_nxt.en = m_r.strap_s2 == vdisp_pkg::STRAP_SERIAL;
        m_nxt.cap_done = 1'b1;
      end else begin
        m_nxt.cap_cnt = m_r.cap_cnt + 2'h1;
      end
    end
    m_nxt.req_s1 = l_r.req_tg;
    m_nxt.req_s2 = m_r.req_s1;
    m_nxt.req_s3 = m_r.req_s2;
    if (m_r.req_s2 != m_r.req_s3) begin
      // link fields stay put until the ack toggle returns
      m_nxt.sub = l_r.sub;
      if (l_r.rd_kind) begin
        m_nxt.rd_stb = 1'b1;
      end else begin
        m_nxt.wdat = l_r.wdat;
        m_nxt.wr_stb = 1'b1;
        m_nxt.ack_tg = !m_r.ack_tg;
      end
    end
    if (m_r.rd_stb) begin
      m_nxt.rdat = RD_DATA;
      m_nxt.ack_tg = !m_r.ack_tg;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      m_r <= '0;
    end else begin
      m_r <= m_nxt;
    end
  end

  assign PORT_EN = m_r.en;
  assign WR_STB = m_r.wr_stb;
  assign RD_STB = m_r.rd_stb;
  assign SUBADDR = m_r.sub;
  assign WR_DATA = m_r.wdat;
  // open drain: only ever pull low, never make start or stop
  assign BUS.dev_scl_o = 1'b0;
  assign BUS.dev_sda_o = 1'b0;
  assign BUS.dev_scl_oe = l_r.scl_low;
  assign BUS.dev_sda_oe = l_r.sda_low;
endmodule : vdisp_dev
`default_nettype wire

//--- vdisp_pkg.sv
// shared constants and types for the video decoder serial host port
package vdisp_pkg;
  // upper six bits of the 7-bit slave address; the lowest comes from a pin
  localparam logic [5:0] ADDR_UPPER = 6'h2e;
  // strap pattern {bit2, bit1, bit0} that enables the serial host port
  localparam logic [2:0] STRAP_SERIAL = 3'h1;
  // edges after reset release before the synchronised straps are valid
  localparam logic [1:0] STRAP_CAP_AT = 2'h2;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam int MCLK_NS = 40;
  // shortest bit period at the top rate of 400 kbit/s
  localparam int BIT_NS = 2500;
  // quarter-bit in MCLK cycles, rounded up so the rate is never exceeded
  localparam int QTR_CYC = (BIT_NS + 4 * MCLK_NS - 1) / (4 * MCLK_NS);
  localparam logic [4:0] QTR_LAST = 5'(QTR_CYC - 1);

  typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_ACK, DS_TXW, DS_TX, DS_TXA} vdisp_dst_t;
  typedef enum logic [1:0] {DR_ADDR, DR_SUB, DR_DATA, DR_TX} vdisp_drole_t;
  typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} vdisp_mst_t;
  typedef enum logic [1:0] {MR_ADDR, MR_SUB, MR_WDATA, MR_RDATA} vdisp_mrole_t;
  // write: subaddress then data bytes; setsub: subaddress only; read: data phase
  typedef enum logic [1:0] {OP_WRITE, OP_SETSUB, OP_READ} vdisp_op_t;
endpackage : vdisp_pkg

//--- vdisp_if.sv
// open-drain serial bus joining the host end and the device end
`timescale 1ns/1ns
`default_nettype none
interface vdisp_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // pulled up; any enabled driver can only pull low
  assign scl = !((host_scl_oe && !host_scl_o) || (dev_scl_oe && !dev_scl_o));
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oe,
               output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface : vdisp_if
`default_nettype wire

//--- vdisp_host.sv
// host end: serial bus master that writes, sets subaddress and reads
`timescale 1ns/1ns
`default_nettype none
module vdisp_host (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire vdisp_pkg::vdisp_op_t CMD_OP,
  input wire logic [6:0] CMD_ADDR,
  input wire logic [7:0] CMD_SUBADDR,
  input wire logic [7:0] CMD_DATA,
  input wire logic [3:0] CMD_COUNT,
  vdisp_if.host BUS,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic DONE,
  output logic NACK
);
  typedef struct packed {
    vdisp_pkg::vdisp_mst_t st;
    vdisp_pkg::vdisp_mrole_t role;
    vdisp_pkg::vdisp_op_t op;
    logic [4:0] qcnt;
    logic [1:0] ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [6:0] addr;
    logic [7:0] sub;
    logic [7:0] data;
    logic [3:0] left;
    logic scl_low;
    logic sda_low;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic ackbit;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic done;
    logic nack;
  } vdisp_hst_t;

  vdisp_hst_t h_r;
  vdisp_hst_t h_nxt;
  logic tick;
  logic step;
  logic is_tx;

  always_comb begin
    h_nxt = h_r;
    h_nxt.rsp_valid = 1'b0;
    h_nxt.done = 1'b0;
    h_nxt.scl_s1 = BUS.scl;
    h_nxt.scl_s2 = h_r.scl_s1;
    h_nxt.sda_s1 = BUS.sda;
    h_nxt.sda_s2 = h_r.sda_s1;
    tick = h_r.qcnt == vdisp_pkg::QTR_LAST;
    // phase 2 needs the clock seen high: a stretching slave holds us here
    step = tick && !(h_r.ph == 2'h2 && !h_r.scl_s2);
    is_tx = h_r.role != vdisp_pkg::MR_RDATA;
    if (h_r.st != vdisp_pkg::MS_IDLE) begin
      h_nxt.qcnt = tick ? 5'h00 : h_r.qcnt + 5'h01;
    end
    if (step) begin
      h_nxt.ph = h_r.ph + 2'h1;
    end
    unique case (h_r.st)
      vdisp_pkg::MS_IDLE: begin
        if (CMD_VALID) begin
          h_nxt.op = CMD_OP;
          h_nxt.addr = CMD_ADDR;
          h_nxt.sub = CMD_SUBADDR;
          h_nxt.data = CMD_DATA;
          h_nxt.left = CMD_COUNT;
          h_nxt.nack = 1'b0;
          h_nxt.qcnt = 5'h00;
          h_nxt.ph = 2'h0;
          h_nxt.st = vdisp_pkg::MS_START;
        end
      end
      vdisp_pkg::MS_START: begin
        if (step) begin
          unique case (h_r.ph)
            2'h0: begin
              h_nxt.scl_low = 1'b0;
              h_nxt.sda_low = 1'b0;
            end
            2'h1: begin
            end
            2'h2: h_nxt.sda_low = 1'b1;
            2'h3: begin
              h_nxt.scl_low = 1'b1;
              h_nxt.sh = {h_r.addr, h_r.op == vdisp_pkg::OP_READ};
              h_nxt.role = vdisp_pkg::MR_ADDR;
              h_nxt.cnt = 4'h0;
              h_nxt.st = vdisp_pkg::MS_BIT;
            end
          endcase
        end
      end
      vdisp_pkg::MS_BIT: begin
        if (step) begin
          unique case (h_r.ph)
            2'h0: begin
              // data only moves with the clock low
              if (h_r.cnt == vdisp_pkg::ACK_BIT) begin
                h_nxt.sda_low = !is_tx && h_r.left != 4'h0;
              end else begin
                h_nxt.sda_low = is_tx && !h_r.sh[7];
              end
            end
            2'h1: h_nxt.scl_low = 1'b0;
            2'h2: begin
              if (h_r.cnt == vdisp_pkg::ACK_BIT) begin
                h_nxt.ackbit = h_r.sda_s2;
              end else if (!is_tx) begin
                h_nxt.sh = {h_r.sh[6:0], h_r.sda_s2};
              end
            end
            2'h3: begin
              h_nxt.scl_low = 1'b1;
              h_nxt.cnt = h_r.cnt + 4'h1;
              if (h_r.cnt != vdisp_pkg::ACK_BIT && is_tx) begin
                h_nxt.sh = {h_r.sh[6:0], 1'b0};
              end
              if (h_r.cnt == vdisp_pkg::ACK_BIT) begin
                h_nxt.cnt = 4'h0;
                if (is_tx && h_r.ackbit) begin
                  h_nxt.nack = 1'b1;
                  h_nxt.st = vdisp_pkg::MS_STOP;
                end else begin
                  unique case (h_r.role)
                    vdisp_pkg::MR_ADDR: begin
                      if (h_r.op == vdisp_pkg::OP_READ) begin
                        h_nxt.role = vdisp_pkg::MR_RDATA;
                      end else begin
                        h_nxt.role = vdisp_pkg::MR_SUB;
                        h_nxt.sh = h_r.sub;
                      end
                    end
                    vdisp_pkg::MR_SUB: begin
                      if (h_r.op == vdisp_pkg::OP_SETSUB) begin
                        h_nxt.st = vdisp_pkg::MS_STOP;
                      end else begin
                        h_nxt.role = vdisp_pkg::MR_WDATA;
                        h_nxt.sh = h_r.data;
                      end
                    end
                    vdisp_pkg::MR_WDATA: begin
                      if (h_r.left == 4'h0) begin
                        h_nxt.st = vdisp_pkg::MS_STOP;
                      end else begin
                        h_nxt.left = h_r.left - 4'h1;
                        h_nxt.sh = h_r.data;
                      end
                    end
                    vdisp_pkg::MR_RDATA: begin
                      h_nxt.rsp_valid = 1'b1;
                      h_nxt.rsp_data = h_r.sh;
                      if (h_r.left == 4'h0) begin
                        h_nxt.st = vdisp_pkg::MS_STOP;
                      end else begin
                        h_nxt.left = h_r.left - 4'h1;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
      end
      vdisp_pkg::MS_STOP: begin
        if (step) begin
          unique case (h_r.ph)
            2'h0: h_nxt.sda_low = 1'b1;
            2'h1: h_nxt.scl_low = 1'b0;
            2'h2: h_nxt.sda_low = 1'b0;
            2'h3: begin
              h_nxt.done = 1'b1;
              h_nxt.st = vdisp_pkg::MS_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign CMD_READY = h_r.st == vdisp_pkg::MS_IDLE;
  assign RSP_VALID = h_r.rsp_valid;
  assign RSP_DATA = h_r.rsp_data;
  assign DONE = h_r.done;
  assign NACK = h_r.nack;
  assign BUS.host_scl_o = 1'b0;
  assign BUS.host_sda_o = 1'b0;
  assign BUS.host_scl_oe = h_r.scl_low;
  assign BUS.host_sda_oe = h_r.sda_low;
endmodule : vdisp_host
`default_nettype wire

//--- vdisp_props.sv
// assertions on the open-drain bus between the host end and the device end
`timescale 1ns/1ns
`default_nettype none
module vdisp_props (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  logic scl_q, sda_q, first_r, rd_r, acked_r, rise;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  assign rise = scl && !scl_q;
  // pulse index since the last start; index 8 of every byte is the ack pulse
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      first_r <= 1'h0;
      rd_r <= 1'h0;
      acked_r <= 1'h0;
      cnt_r <= 4'h0;
      sh_r <= 8'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        cnt_r <= 4'h0;
        first_r <= 1'h1;
        acked_r <= 1'h0;
      end else if (rise) begin
        sh_r <= {sh_r[6:0], sda};
        cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
        if (first_r && cnt_r == 4'h7) rd_r <= sda;
        if (first_r && cnt_r == 4'h8) first_r <= 1'h0;
        if (first_r && cnt_r == 4'h8) acked_r <= dev_sda_oe;
        // a read ends at the master's nack; the stop that follows is no data bit
        if (!first_r && rd_r && cnt_r == 4'h8 && sda) begin
          acked_r <= 1'h0;
        end
      end
    end
  end
  a_dev_od_low: assert property (!dev_scl_o && !dev_sda_o)
    else $error("device end drives a line high");
  a_host_od_low: assert property (!host_scl_o && !host_sda_o)
    else $error("host end drives a line high");
  a_dev_sda_edge: assert property ($changed(dev_sda_oe) |-> !$past(scl))
    else $error("device moved data while clock high");
  a_stretch_low: assert property ($rose(dev_scl_oe) |-> !$past(scl))
    else $error("device pulled clock while it was high");
  a_stretch_end: assert property ($rose(dev_scl_oe) |-> ##[1:64] !dev_scl_oe)
    else $error("clock stretch too long");
  a_addr_nack: assert property (rise && cnt_r == 4'h8 && first_r &&
    sh_r[7:2] != vdisp_pkg::ADDR_UPPER |-> !dev_sda_oe)
    else $error("foreign address acknowledged");
  a_quiet_unacked: assert property (rise && !first_r && !acked_r |-> !dev_sda_oe)
    else $error("device drives data while not addressed");
  a_write_ack: assert property (rise && cnt_r == 4'h8 && !first_r && !rd_r && acked_r
    |-> dev_sda_oe)
    else $error("written byte not acknowledged");
  a_host_ack_free: assert property (rise && cnt_r == 4'h8 && (first_r || !rd_r)
    |-> !host_sda_oe)
    else $error("host holds data during slave ack");
  a_host_rd_free: assert property (rise && rd_r && acked_r && !first_r &&
    cnt_r != 4'h8 |-> !host_sda_oe)
    else $error("host drives data during read byte");
  a_dev_rd_release: assert property (rise && cnt_r == 4'h8 && rd_r && !first_r
    |-> !dev_sda_oe)
    else $error("device holds data during master ack");
endmodule : vdisp_props
`default_nettype wire

//--- test_video_decoder_i2c_slave_port.sv
// self-checking bench: host end talks to device end across the serial bus
`timescale 1ns/1ns
`default_nettype none
module test_video_decoder_i2c_slave_port;
  logic mclk = 1'h0, link_clk = 1'h0, rst_n = 1'h0, sel = 1'h0, cmd_valid = 1'h0;
  logic cmd_ready, rsp_valid, done, nack, port_en, wr_stb, rd_stb;
  logic [2:0] strap = 3'h1;
  vdisp_pkg::vdisp_op_t cmd_op = vdisp_pkg::OP_WRITE;
  logic [6:0] cmd_addr = 7'h0;
  logic [7:0] cmd_sub = 8'h0, cmd_data = 8'h0, rsp_data, subaddr, wr_data, rd_data, rs, rv;
  logic [3:0] cmd_cnt = 4'h0, rn;
  logic [7:0] mem [256];
  int bad_count = 0, cmp_count = 0, cyc = 0, seed = 32'hb171, p, i;
  always #20 mclk = ~mclk;
  initial begin
    #7;
    forever #80 link_clk = ~link_clk;
  end
  // register side answers in the strobe cycle, as the device expects
  assign rd_data = mem[subaddr];
  vdisp_if vdisp_if_inst ();
  vdisp_dev vdisp_dev_inst (.MCLK(mclk), .RESETN(rst_n), .LINK_CLK(link_clk),
    .STRAP_BIT2_PIN(strap[2]), .STRAP_BIT1_PIN(strap[1]), .STRAP_BIT0_PIN(strap[0]),
    .ADDR_SELECT_PIN(sel), .BUS(vdisp_if_inst.dev), .PORT_EN(port_en), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .SUBADDR(subaddr), .WR_DATA(wr_data), .RD_DATA(rd_data));
  vdisp_host vdisp_host_inst (.MCLK(mclk), .RESETN(rst_n), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr), .CMD_SUBADDR(cmd_sub),
    .CMD_DATA(cmd_data), .CMD_COUNT(cmd_cnt), .BUS(vdisp_if_inst.host),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .DONE(done), .NACK(nack));
  vdisp_props vdisp_props_inst (.MCLK(mclk), .RESETN(rst_n),
    .host_scl_o(vdisp_if_inst.host_scl_o), .host_scl_oe(vdisp_if_inst.host_scl_oe),
    .host_sda_o(vdisp_if_inst.host_sda_o), .host_sda_oe(vdisp_if_inst.host_sda_oe),
    .dev_scl_o(vdisp_if_inst.dev_scl_o), .dev_scl_oe(vdisp_if_inst.dev_scl_oe),
    .dev_sda_o(vdisp_if_inst.dev_sda_o), .dev_sda_oe(vdisp_if_inst.dev_sda_oe),
    .scl(vdisp_if_inst.scl), .sda(vdisp_if_inst.sda));
  function automatic logic [6:0] exp_addr(input logic s);
    return {vdisp_pkg::ADDR_UPPER, s};
  endfunction : exp_addr
  function automatic logic exp_en(input logic [2:0] s);
    return s == vdisp_pkg::STRAP_SERIAL;
  endfunction : exp_en
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (e !== g) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic do_reset(input logic [2:0] s);
    rst_n = 1'h0;
    strap = s;
    repeat (16) @(posedge mclk);
    #1 rst_n = 1'h1;
    repeat (48) @(posedge mclk);
    // straps move after capture; the mode must not follow them
    #1 strap = ~s;
  endtask : do_reset
  task automatic cmd(input vdisp_pkg::vdisp_op_t op, input logic [6:0] a,
      input logic [7:0] s, input logic [7:0] d, input logic [3:0] n, input logic ok);
    int t, w, r, q;
    w = 0;
    r = 0;
    q = 0;
    for (t = 0; t < 99 && cmd_ready !== 1'h1; t++) begin
      @(posedge mclk);
      #1;
    end
    cmd_op = op;
    cmd_addr = a;
    cmd_sub = s;
    cmd_data = d;
    cmd_cnt = n;
    cmd_valid = 1'h1;
    @(posedge mclk);
    #1 cmd_valid = 1'h0;
    for (t = 0; t < 20000 && done !== 1'h1; t++) begin
      if (wr_stb === 1'h1) begin
        w++;
        chk("wr_data", d, wr_data);
        chk("wr_sub", s, subaddr);
      end
      if (rd_stb === 1'h1) begin
        r++;
        chk("rd_sub", s, subaddr);
      end
      if (rsp_valid === 1'h1) begin
        q++;
        chk("rsp_data", mem[s], rsp_data);
      end
      @(posedge mclk);
      #1;
    end
    if (op == vdisp_pkg::OP_WRITE && ok) mem[s] = d;
    chk("done", 32'h1, done);
    chk("ready", 32'h1, cmd_ready);
    chk("nack", !ok, nack);
    chk("writes", (op == vdisp_pkg::OP_WRITE && ok) ? n + 32'h1 : 32'h0, w);
    chk("reads", (op == vdisp_pkg::OP_READ && ok) ? n + 32'h1 : 32'h0, r);
    chk("rsps", (op == vdisp_pkg::OP_READ && ok) ? n + 32'h1 : 32'h0, q);
  endtask : cmd
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 99000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    for (i = 0; i < 256; i++) mem[i] = 8'($random(seed));
    for (p = 0; p < 8; p++) begin
      do_reset(3'(p));
      sel = 1'(p);
      cmd(vdisp_pkg::OP_WRITE, exp_addr(sel), 8'(p), 8'h5a, 4'h0, exp_en(3'(p)));
      chk("port_en", exp_en(3'(p)), port_en);
    end
    do_reset(vdisp_pkg::STRAP_SERIAL);
    for (i = 0; i < 4; i++) begin
      sel = 1'($random(seed));
      rs = 8'($random(seed));
      rv = 8'($random(seed));
      rn = 4'($random(seed) & 3);
      cmd(vdisp_pkg::OP_WRITE, exp_addr(sel), rs, rv, rn, 1'h1);
      cmd(vdisp_pkg::OP_SETSUB, exp_addr(sel), rs, 8'h0, 4'h0, 1'h1);
      cmd(vdisp_pkg::OP_READ, exp_addr(sel), rs, 8'h0, rn, 1'h1);
      cmd(vdisp_pkg::OP_WRITE, exp_addr(!sel), rs, 8'h0, 4'h0, 1'h0);
    end
    cmd(vdisp_pkg::OP_READ, 7'h11, 8'h0, 8'h0, 4'h0, 1'h0);
    cmd(vdisp_pkg::OP_WRITE, exp_addr(sel), 8'hff, 8'h00, 4'hf, 1'h1);
    cmd(vdisp_pkg::OP_SETSUB, exp_addr(sel), 8'hff, 8'h0, 4'h0, 1'h1);
    cmd(vdisp_pkg::OP_READ, exp_addr(sel), 8'hff, 8'h0, 4'hf, 1'h1);
    give_verdict();
  end
endmodule : test_video_decoder_i2c_slave_port
`default_nettype wire
